// ### hdl/pmp_pkg.sv
// constants and carrier types for one port's media independent interface
// assumes a 25 MHz reference clock; line side and mac side share it
package pmp_pkg;
    localparam int REF_CLK_HZ    = 25_000_000;
    localparam int SLOW_MII_HZ   = 2_500_000;
    localparam int MDC_MAX_HZ    = 20_000_000;
    localparam int SLOW_HALF_CYC = REF_CLK_HZ / (2 * SLOW_MII_HZ);
    localparam logic [2:0] DIV_LAST  = 3'(SLOW_HALF_CYC - 1);
    localparam logic [5:0] PRE_MIN   = 6'h20;
    localparam logic [3:0] HDR_LAST  = 4'hc;
    localparam logic [3:0] DATA_LAST = 4'hf;
    localparam logic [1:0] OP_READ   = 2'h2;
    localparam logic [1:0] OP_WRITE  = 2'h1;
    localparam logic [4:0] REG_CTRL  = 5'h00;
    localparam logic [4:0] REG_CFG   = 5'h10;
    localparam logic [4:0] REG_STAT  = 5'h11;
    localparam int CTRL_SPEED_BIT  = 13;
    localparam int CTRL_DUPLEX_BIT = 8;
    localparam int CFG_SYMBOL_BIT  = 0;
    localparam int STAT_RXACT_BIT  = 0;
    localparam int STAT_COL_BIT    = 1;
    localparam int STAT_CRS_BIT    = 2;
    localparam int STAT_TXACT_BIT  = 3;
    localparam int STAT_MDIS_BIT   = 4;

    typedef struct packed {
        logic       en;
        logic       er;
        logic [3:0] d;
    } pmp_mii_tx_s;

    typedef struct packed {
        logic       dv;
        logic       er;
        logic [3:0] d;
    } pmp_mii_rx_s;

    typedef struct packed {
        logic       valid;
        logic       halt;
        logic       symMode;
        logic [4:0] sym;
    } pmp_line_tx_s;

    typedef struct packed {
        logic       active;
        logic       valid;
        logic       bad;
        logic [4:0] sym;
    } pmp_line_rx_s;

    typedef struct packed {
        logic       speed100;
        logic       fullDup;
        logic       mgmtDis;
        logic [4:0] addr;
    } pmp_straps_s;

    typedef enum logic [2:0] {M_IDLE, M_HDR, M_TA1, M_TA2, M_DATA} pmp_mdio_e;
endpackage

// ### hdl/pmp_port.sv
// one port: mii nibble paths, carrier and collision, management slave
// assumes line side logic on ref_clk; mdc, mdio and straps are asynchronous pins
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
module pmp_port
(
    input  logic                  ref_clk,
    input  logic                  rst,
    input  pmp_pkg::pmp_mii_tx_s  miiTx,
    output logic                  txClk,
    output logic                  rxClk,
    output pmp_pkg::pmp_mii_rx_s  miiRx,
    output logic                  col,
    output logic                  crs,
    input  logic                  mdc,
    input  logic                  mdioIn,
    output logic                  mdioOut,
    output logic                  mdioOeN,
    input  pmp_pkg::pmp_straps_s  straps,
    output pmp_pkg::pmp_line_tx_s lineTx,
    input  pmp_pkg::pmp_line_rx_s lineRx,
    input  logic [4:0]            regAddr,
    input  logic [15:0]           regWdata,
    input  logic                  regWr,
    input  logic                  regRd,
    output logic [15:0]           regRdata
);
    import pmp_pkg::*;

    localparam int PIN_W = 2 + $bits(pmp_straps_s);

    logic [PIN_W-1:0] pinS1Q;
    logic [PIN_W-1:0] pinS2Q;
    logic             mdcS;
    logic             mdiS;
    pmp_straps_s      strapS;

    // not reset: the straps must reach the registers while rst is still held
    always_ff @(posedge ref_clk)
    begin
        pinS1Q <= {mdc, mdioIn, straps};
        pinS2Q <= pinS1Q;
    end
    assign {mdcS, mdiS, strapS} = pinS2Q;

    // registers and straps
    logic        speed100Q, speed100D;
    logic        fullDupQ, fullDupD;
    logic        symModeQ, symModeD;
    logic        mgmtDisQ;
    logic [4:0]  phyAddrQ;
    logic [15:0] rdQ, rdD;
    logic        mWr;
    logic        wrEn;
    logic [4:0]  wrA;
    logic [15:0] wrV;
    logic [4:0]  raddrM;
    logic [15:0] mWrData;
    logic        colQ, colD;
    logic        crsQ, crsD;
    pmp_line_tx_s lineTxQ, lineTxD;

    function automatic logic [15:0] regView(input logic [4:0] a);
        logic [15:0] v;
        v = '0;
        unique case (a)
            REG_CTRL:
            begin
                v[CTRL_SPEED_BIT]  = speed100Q;
                v[CTRL_DUPLEX_BIT] = fullDupQ;
            end
            REG_CFG:  v[CFG_SYMBOL_BIT] = symModeQ;
            REG_STAT:
            begin
                v[STAT_RXACT_BIT] = lineRx.active;
                v[STAT_COL_BIT]   = colQ;
                v[STAT_CRS_BIT]   = crsQ;
                v[STAT_TXACT_BIT] = lineTxQ.valid;
                v[STAT_MDIS_BIT]  = mgmtDisQ;
            end
            default: v = '0;
        endcase
        return v;
    endfunction

    // local port write wins over a management write in the same cycle
    assign wrEn = regWr || mWr;
    assign wrA  = regWr ? regAddr : raddrM;
    assign wrV  = regWr ? regWdata : mWrData;

    always_comb
    begin
        speed100D = speed100Q;
        fullDupD  = fullDupQ;
        symModeD  = symModeQ;
        rdD       = regRd ? regView(regAddr) : '0;
        if (wrEn)
        begin
            unique case (wrA)
                REG_CTRL:
                begin
                    speed100D = wrV[CTRL_SPEED_BIT];
                    fullDupD  = wrV[CTRL_DUPLEX_BIT];
                end
                REG_CFG: symModeD = wrV[CFG_SYMBOL_BIT];
                default: ;
            endcase
        end
    end

    // pins load the bits while reset is held; rst needs three edges
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            speed100Q <= strapS.speed100;
            fullDupQ  <= strapS.fullDup;
            symModeQ  <= 1'b0;
            mgmtDisQ  <= strapS.mgmtDis;
            phyAddrQ  <= strapS.addr;
            rdQ       <= '0;
        end
        else
        begin
            speed100Q <= speed100D;
            fullDupQ  <= fullDupD;
            symModeQ  <= symModeD;
            rdQ       <= rdD;
        end
    end

    // slow mii clock divider, free running
    logic [2:0] divCntQ, divCntD;
    logic       divClkQ, divClkD;
    logic       nibStrobe;

    always_comb
    begin
        divCntD = divCntQ + 3'h1;
        divClkD = divClkQ;
        if (divCntQ == DIV_LAST)
        begin
            divCntD = '0;
            divClkD = !divClkQ;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            divCntQ <= '0;
            divClkQ <= 1'b0;
        end
        else
        begin
            divCntQ <= divCntD;
            divClkQ <= divClkD;
        end
    end

    // mac data settles after one clock rise and is taken at the next
    assign nibStrobe = speed100Q || (divCntQ == DIV_LAST && !divClkQ);
    assign txClk     = speed100Q ? ref_clk : divClkQ;
    assign rxClk     = speed100Q ? ref_clk : divClkQ;

    // nibble paths, carrier and collision
    pmp_mii_rx_s miiRxQ, miiRxD;

    always_comb
    begin
        lineTxD = lineTxQ;
        miiRxD  = miiRxQ;
        if (nibStrobe)
        begin
            lineTxD.valid   = miiTx.en;
            lineTxD.symMode = symModeQ;
            lineTxD.sym     = symModeQ ? {miiTx.er, miiTx.d} : {1'b0, miiTx.d};
            lineTxD.halt    = !symModeQ && speed100Q && miiTx.en && miiTx.er;
            miiRxD.d        = lineRx.sym[3:0];
            miiRxD.dv       = lineRx.valid;
            miiRxD.er       = symModeQ ? lineRx.sym[4] : lineRx.bad;
        end
        colD = !fullDupQ && miiTx.en && lineRx.active;
        crsD = lineRx.active || (!fullDupQ && miiTx.en);
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            lineTxQ <= '0;
            miiRxQ  <= '0;
            colQ    <= 1'b0;
            crsQ    <= 1'b0;
        end
        else
        begin
            lineTxQ <= lineTxD;
            miiRxQ  <= miiRxD;
            colQ    <= colD;
            crsQ    <= crsD;
        end
    end

    // management slave, stepped on each sampled mdc rise
    pmp_mdio_e   mStQ, mStD;
    logic [5:0]  preCntQ, preCntD;
    logic [3:0]  bitCntQ, bitCntD;
    logic [12:0] hdrQ, hdrD;
    logic [15:0] shQ, shD;
    logic        mdoQ, mdoD;
    logic        oeNQ, oeND;
    logic        mdcLastQ;
    logic        mdcRise;
    logic        isRead;
    logic        isWrite;

    assign mdcRise = mdcS && !mdcLastQ;
    assign raddrM  = hdrQ[4:0];
    assign mWrData = {shQ[14:0], mdiS};
    assign isRead  = hdrQ[12] && hdrQ[11:10] == OP_READ && hdrQ[9:5] == phyAddrQ;
    assign isWrite = hdrQ[12] && hdrQ[11:10] == OP_WRITE && hdrQ[9:5] == phyAddrQ;

    always_comb
    begin
        mStD    = mStQ;
        preCntD = preCntQ;
        bitCntD = bitCntQ;
        hdrD    = hdrQ;
        shD     = shQ;
        mdoD    = mdoQ;
        oeND    = oeNQ;
        mWr     = 1'b0;
        if (mgmtDisQ)
        begin
            mStD    = M_IDLE;
            preCntD = '0;
            oeND    = 1'b1;
        end
        else if (mdcRise)
        begin
            unique case (mStQ)
                M_IDLE:
                begin
                    if (mdiS)
                        preCntD = (preCntQ == PRE_MIN) ? preCntQ : preCntQ + 6'h01;
                    else
                    begin
                        if (preCntQ == PRE_MIN)
                        begin
                            mStD    = M_HDR;
                            bitCntD = '0;
                        end
                        preCntD = '0;
                    end
                end
                M_HDR:
                begin
                    hdrD    = {hdrQ[11:0], mdiS};
                    bitCntD = bitCntQ + 4'h1;
                    if (bitCntQ == HDR_LAST)
                        mStD = M_TA1;
                end
                M_TA1:
                begin
                    mStD = M_TA2;
                    if (isRead)
                    begin
                        oeND = 1'b0;
                        mdoD = 1'b0;
                        shD  = regView(raddrM);
                    end
                end
                M_TA2:
                begin
                    mStD    = M_DATA;
                    bitCntD = '0;
                    if (isRead)
                    begin
                        mdoD = shQ[15];
                        shD  = {shQ[14:0], 1'b0};
                    end
                end
                M_DATA:
                begin
                    bitCntD = bitCntQ + 4'h1;
                    if (isRead)
                    begin
                        mdoD = shQ[15];
                        shD  = {shQ[14:0], 1'b0};
                    end
                    else
                        shD = {shQ[14:0], mdiS};
                    if (bitCntQ == DATA_LAST)
                    begin
                        mStD = M_IDLE;
                        oeND = 1'b1;
                        mWr  = isWrite;
                    end
                end
                default: mStD = M_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            mStQ     <= M_IDLE;
            preCntQ  <= '0;
            bitCntQ  <= '0;
            hdrQ     <= '0;
            shQ      <= '0;
            mdoQ     <= 1'b0;
            oeNQ     <= 1'b1;
            mdcLastQ <= 1'b0;
        end
        else
        begin
            mStQ     <= mStD;
            preCntQ  <= preCntD;
            bitCntQ  <= bitCntD;
            hdrQ     <= hdrD;
            shQ      <= shD;
            mdoQ     <= mdoD;
            oeNQ     <= oeND;
            mdcLastQ <= mdcS;
        end
    end

    assign lineTx   = lineTxQ;
    assign miiRx    = miiRxQ;
    assign col      = colQ;
    assign crs      = crsQ;
    assign mdioOut  = mdoQ;
    assign mdioOeN  = oeNQ;
    assign regRdata = rdQ;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_tx_normal_nibble: assert property
        ((nibStrobe && !symModeQ) |=> lineTxQ.sym == {1'b0, $past(miiTx.d)})
        else $error("tx nibble not taken from data bits");
    a_txer_slow_off: assert property
        ((nibStrobe && !speed100Q) |=> !lineTxQ.halt)
        else $error("halt sent at low speed");
    a_txer_halt_sent: assert property
        ((nibStrobe && speed100Q && !symModeQ && miiTx.en && miiTx.er) |=> lineTxQ.halt)
        else $error("tx error did not send halt");
    a_tx_fifth_bit: assert property
        ((nibStrobe && symModeQ) |=> lineTxQ.sym[4] == $past(miiTx.er) && !lineTxQ.halt)
        else $error("symbol mode fifth tx bit wrong");
    a_slow_clock_shape: assert property
        ($rose(divClkQ) |-> divClkQ[*5] ##1 !divClkQ[*5])
        else $error("slow mii clock period wrong");
    a_rx_nibble_valid: assert property
        (nibStrobe |=> miiRxQ.dv == $past(lineRx.valid) && miiRxQ.d == $past(lineRx.sym[3:0]))
        else $error("rx nibble or valid not passed");
    a_rx_err_flag: assert property
        ((nibStrobe && !symModeQ && lineRx.bad) |=> miiRxQ.er)
        else $error("invalid symbol not flagged");
    a_rx_fifth_bit: assert property
        ((nibStrobe && symModeQ) |=> miiRxQ.er == $past(lineRx.sym[4]))
        else $error("symbol mode fifth rx bit wrong");
    a_col_tracks: assert property
        ((!fullDupQ && miiTx.en && lineRx.active) |=> colQ)
        else $error("collision not raised");
    a_col_full_dup: assert property
        ($past(fullDupQ) |-> !colQ)
        else $error("collision in full duplex");
    a_crs_half_dup: assert property
        ((!fullDupQ && (miiTx.en || lineRx.active)) |=> crsQ)
        else $error("carrier missing in half duplex");
    a_crs_full_dup: assert property
        ((fullDupQ && !lineRx.active) |=> !crsQ)
        else $error("carrier from own tx in full duplex");
    a_mdio_disabled: assert property
        (mgmtDisQ |-> mdioOeN && mStQ == M_IDLE)
        else $error("management active while disabled");
    a_mdio_own_turn: assert property
        ((mStQ == M_IDLE || mStQ == M_HDR || mStQ == M_TA1) |-> mdioOeN)
        else $error("data line driven in station part");

    c_mdio_read: cover property (mStQ == M_TA1 && mdcRise && isRead);
    c_mdio_write: cover property (mWr);
    c_collision: cover property (colQ);
    c_halt_sent: cover property (lineTxQ.halt);
endmodule

// ### sim/pmp_station.sv
// management station model: clause 22 frames over mdc and mdio
// assumes the bench resolves the mdio line with a pull-up
`timescale 1ns/1ps
module pmp_station
(
    output logic      mdcSta,
    output logic      staOeN,
    output logic      staBit,
    input  wire logic mdioLine
);
    // mdc stands low between frames; 320 ns period
    initial
    begin
        mdcSta = 1'b0;
        staOeN = 1'b1;
        staBit = 1'b1;
    end

    // one bit: set on the low phase, sample at the rising edge
    task automatic tick(input logic b, input logic drv, output logic s);
        staOeN = ~drv;
        staBit = drv ? b : 1'b1;
        #160 mdcSta = 1'b1;
        s = mdioLine;
        #160 mdcSta = 1'b0;
    endtask

    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [45:0] hdr;
        logic        s;
        hdr = {32'hffff_ffff, 2'h1, op, phy, ra};
        rd = 16'h0000;
        for (int i = 45; i >= 0; i--)
            tick(hdr[i], 1'b1, s);
        // turnaround: a read leaves the line to the port
        tick(1'b1, op == 2'h1, s);
        tick(1'b0, op == 2'h1, s);
        for (int i = 15; i >= 0; i--)
        begin
            tick(wd[i], op == 2'h1, s);
            rd[i] = s;
        end
        staOeN = 1'b1;
        staBit = 1'b1;
    endtask
endmodule

// ### sim/pmp_port_bench.sv
// bench for one port: mii paths, carrier, collision, registers, mdio
// assumes pmp_station on a pulled-up mdio line; inputs driven on ref_clk
`timescale 1ns/1ps
module pmp_port_bench;
    import pmp_pkg::*;
    logic         ref_clk;
    logic         rst;
    pmp_mii_tx_s  miiTx;
    pmp_mii_rx_s  miiRx;
    pmp_line_tx_s lineTx;
    pmp_line_rx_s lineRx;
    pmp_straps_s  straps;
    logic         txClk, rxClk, col, crs, mdc, mdioOut, mdioOeN, staOeN, staBit, regWr, regRd;
    wire          mdioLine;
    logic [4:0]   regAddr;
    logic [15:0]  regWdata, regRdata, v;
    logic [7:0]   rises, diff;
    int           errCount, cmpCount;
    int           cycles = 0;

    // pull-up when neither party drives
    assign mdioLine = !mdioOeN ? mdioOut : (!staOeN ? staBit : 1'b1);

    pmp_port pmp_port_i (.ref_clk, .rst, .miiTx, .txClk, .rxClk, .miiRx, .col, .crs, .mdc,
        .mdioIn(mdioLine), .mdioOut, .mdioOeN, .straps, .lineTx, .lineRx, .regAddr, .regWdata,
        .regWr, .regRd, .regRdata);
    pmp_station pmp_station_i (.mdcSta(mdc), .staOeN, .staBit, .mdioLine);

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic testDone();
        $display("checks %0d mismatches %0d", cmpCount, errCount);
        if (errCount == 0 && cmpCount > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 8000)
        begin
            errCount++;
            testDone();
        end
    end

    task automatic checkReg(input string what, input logic [15:0] e, input logic [15:0] g);
        cmpCount++;
        if (g !== e)
        begin
            errCount++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic checkPin(input string what, input logic [7:0] e, input logic [7:0] g);
        cmpCount++;
        if (g !== e)
        begin
            errCount++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic regWrite(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge ref_clk);
        regWr    <= 1'b0;
    endtask

    task automatic regRead(input logic [4:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge ref_clk);
        regRd   <= 1'b0;
        #1;
        d = regRdata;
    endtask

    task automatic resetPort(input pmp_straps_s s);
        @(posedge ref_clk);
        straps <= s;
        rst    <= 1'b1;
        repeat (8) @(posedge ref_clk);
        rst    <= 1'b0;
    endtask

    // drive one tx nibble and one line symbol, check both paths n edges later
    task automatic nib(input pmp_mii_tx_s t, input pmp_line_rx_s r, input int n,
                       input pmp_line_tx_s et, input pmp_mii_rx_s er);
        @(posedge ref_clk);
        miiTx  <= t;
        lineRx <= r;
        repeat (n) @(posedge ref_clk);
        #1;
        checkPin("lineTx", et, lineTx);
        checkPin("miiRx", {2'h0, er}, {2'h0, miiRx});
    endtask

    task automatic carrier(input logic en, input logic act, input logic [1:0] e);
        @(posedge ref_clk);
        miiTx.en      <= en;
        lineRx.active <= act;
        repeat (2) @(posedge ref_clk);
        #1;
        checkPin("col crs", {6'h00, e}, {6'h00, col, crs});
    endtask

    task automatic clkRate(output logic [7:0] r, output logic [7:0] d);
        logic prev;
        r = 8'h00;
        d = 8'h00;
        prev = txClk;
        repeat (40)
        begin
            @(posedge ref_clk);
            #1;
            r += 8'(txClk & ~prev);
            d += 8'(rxClk !== txClk);
            prev = txClk;
        end
    endtask

    initial
    begin
        rst      = 1'b1;
        miiTx    = '0;
        lineRx   = '0;
        straps   = 8'h85;
        regAddr  = 5'h00;
        regWdata = 16'h0000;
        regWr    = 1'b0;
        regRd    = 1'b0;
        errCount = 0;
        cmpCount = 0;
        resetPort(8'h85);
        regRead(REG_CTRL, v);
        checkReg("ctrl", 16'h2000, v);
        regWrite(5'h1f, 16'hffff);
        regRead(5'h1f, v);
        checkReg("unmapped", 16'h0000, v);
        regWrite(REG_STAT, 16'hffff);
        regRead(REG_STAT, v);
        checkReg("status", 16'h0000, v);
        $display("test registers done");

        nib(6'h2a, 8'hcc, 2, 8'h8a, 6'h2c);
        nib(6'h35, 8'hf3, 2, 8'hc5, 6'h33);
        nib(6'h00, 8'h00, 2, 8'h00, 6'h00);
        regWrite(REG_CFG, 16'h0001);
        nib(6'h36, 8'hd7, 2, 8'hb6, 6'h37);
        nib(6'h26, 8'he7, 2, 8'ha6, 6'h27);
        regWrite(REG_CFG, 16'h0000);
        nib(6'h00, 8'h00, 2, 8'h00, 6'h00);
        @(posedge ref_clk);
        #10 checkPin("fast clocks high", 8'h03, {6'h00, txClk, rxClk});
        #20 checkPin("fast clocks low", 8'h00, {6'h00, txClk, rxClk});
        $display("test nibble paths done");

        carrier(1'b1, 1'b1, 2'h3);
        carrier(1'b1, 1'b1, 2'h3);
        carrier(1'b1, 1'b0, 2'h1);
        carrier(1'b0, 1'b1, 2'h1);
        carrier(1'b0, 1'b0, 2'h0);
        regWrite(REG_CTRL, 16'h2100);
        carrier(1'b1, 1'b1, 2'h1);
        carrier(1'b1, 1'b0, 2'h0);
        carrier(1'b0, 1'b0, 2'h0);
        $display("test carrier done");

        regWrite(REG_CTRL, 16'h0000);
        clkRate(rises, diff);
        checkPin("slow clock rises", 8'h04, rises);
        checkPin("rx tx clock differ", 8'h00, diff);
        nib(6'h39, 8'hc9, 12, 8'h89, 6'h29);
        nib(6'h00, 8'h00, 12, 8'h00, 6'h00);
        $display("test slow speed done");

        pmp_station_i.frame(OP_WRITE, 5'h05, REG_CTRL, 16'h2100, v);
        repeat (4) @(posedge ref_clk);
        regRead(REG_CTRL, v);
        checkReg("mdio write", 16'h2100, v);
        pmp_station_i.frame(OP_READ, 5'h05, REG_CTRL, 16'h0000, v);
        checkReg("mdio read", 16'h2100, v);
        pmp_station_i.frame(OP_READ, 5'h06, REG_CTRL, 16'h0000, v);
        checkReg("other address read", 16'hffff, v);
        pmp_station_i.frame(OP_WRITE, 5'h06, REG_CTRL, 16'h0000, v);
        repeat (4) @(posedge ref_clk);
        regRead(REG_CTRL, v);
        checkReg("other address write", 16'h2100, v);
        $display("test management done");

        resetPort(8'h65);
        regRead(REG_CTRL, v);
        checkReg("strap ctrl", 16'h0100, v);
        regRead(REG_STAT, v);
        checkReg("strap status", 16'h0010, v);
        pmp_station_i.frame(OP_READ, 5'h05, REG_CTRL, 16'h0000, v);
        checkReg("disabled read", 16'hffff, v);
        pmp_station_i.frame(OP_WRITE, 5'h05, REG_CTRL, 16'h2000, v);
        repeat (4) @(posedge ref_clk);
        regRead(REG_CTRL, v);
        checkReg("disabled write", 16'h0100, v);
        $display("test management disable done");
        testDone();
    end
endmodule
